// file: rtl/ndefac_defines.svh
// Purpose: constants of the tag file access control block
// Assumes: byte-addressed 16-bit file offsets, 16-bit status words
// Notes:   Function
// Function
// - Select names a file by two-byte identifier; three distinct identifiers.
// - Container file is read-only; ordinary writes leave it unchanged.
// - Container type and right bytes change only via dedicated procedures.
// - Container offset zero reads a length of fifteen bytes.
// - Max read and write size both report 246 at their offsets.
// - File-control entry: type 4, length 6, user id, size 8192.
// - Read and write right bytes sit last in container, shipped zero.
// - User file starts with host-managed message length, never checked.
// - Standard read served only inside stored message, else error.
// - Configuration file readable, not writable, length field eighteen.
// - Configuration holds fixed seven-byte serial from offset eight.
// - Read right: 0 free, 128 needs read secret, 254 refuses.
// - Write right: 0 free, 128 needs write secret, 255 refuses.
// - Permanent denial states can never be left, even with secrets.
// - Two separate 128-bit secrets, one for read, one for write.
// - Read-locked user file readable only after read secret verified.
// - Write-locked user file updatable only after write secret verified.
// - Right byte changes accepted only after write secret verified.
// - Permanently locked access stays denied regardless of secrets.
// - Granted permissions clear at session end or different selection.
// - Device only responds; silent until host sends a command.
`ifndef NDEFAC_DEFINES_SVH
`define NDEFAC_DEFINES_SVH
// ==========================================================
// File identifiers
`define FID_SYS         16'hE101
`define FID_CC          16'hE103
`define FID_NDEF        16'h0001
// ==========================================================
// Container layout
`define CC_OFF_LEN      4'h0
`define CC_OFF_MAP      4'h2
`define CC_OFF_MAXRD    4'h3
`define CC_OFF_MAXWR    4'h5
`define CC_OFF_T        4'h7
`define CC_OFF_L        4'h8
`define CC_OFF_FID      4'h9
`define CC_OFF_MAXSZ    4'hB
`define CC_OFF_RDR      4'hD
`define CC_OFF_WRR      4'hE
`define CC_LEN          16'h000F
`define CC_MAX_XFER     16'h00F6
`define CC_TLV_T        8'h04
`define CC_TLV_L        8'h06
`define NDEF_MAX_SIZE   16'h2000
// ==========================================================
// Configuration file layout
`define SYS_LEN         16'h0012
`define SYS_B2          8'h01
`define SYS_B3          8'h00
`define SYS_B4          8'h11
`define SYS_B5          8'h00
`define SYS_B7          8'h00
`define SYS_OFF_UID     5'h08
`define SYS_OFF_MSZ     5'h0F
`define SYS_OFF_PC      5'h11
`define SYS_MEM_SIZE    16'h1FFF
// ==========================================================
// Access right codes
`define RIGHT_FREE      8'h00
`define RIGHT_LOCKED    8'h80
`define RIGHT_NO_READ   8'hFE
`define RIGHT_NO_WRITE  8'hFF
// ==========================================================
// Status words
`define SW_OK           16'h9000
`define SW_NOT_FOUND    16'h6A82
`define SW_SECURITY     16'h6982
`define SW_READ_ONLY    16'h6981
`define SW_NO_SELECT    16'h6986
`define SW_WRONG_PARAM  16'h6A86
`define SW_WRONG_DATA   16'h6A80
`define SW_WRONG_PW     16'h6300
`define SW_BAD_INS      16'h6D00
`endif

// file: rtl/ndefac_pkg.sv
// Purpose: types of the tag file access control block
// Assumes: nothing beyond the defines header
// Notes:   command and response carriers
package ndefac_pkg;
  typedef enum logic [2:0] {
    OP_SELECT = 3'b000,
    OP_READ   = 3'b001,
    OP_UPDATE = 3'b010,
    OP_VFY_RD = 3'b011,
    OP_VFY_WR = 3'b100,
    OP_SET_RD = 3'b101,
    OP_SET_WR = 3'b110
  } ndefac_op_t;
  typedef enum logic [1:0] {
    FS_NONE = 2'b00,
    FS_SYS  = 2'b01,
    FS_CC   = 2'b10,
    FS_NDEF = 2'b11
  } ndefac_file_t;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_WRITE = 2'b10
  } ndefac_state_t;
  typedef struct packed {
    ndefac_op_t    op;
    logic [15:0]   user_file_identifier;
    logic [15:0]   offset;
    logic [7:0]    length;
    logic [127:0]  secret;
    logic [7:0]    newRight;
  } ndefac_cmd_t;
  typedef struct packed {
    logic          valid;
    logic [15:0]   status;
  } ndefac_rsp_t;
endpackage : ndefac_pkg

// file: rtl/ndefac_file_access_control.sv
// Purpose: file selection, access rights and bounded reads of the tag
// Assumes: commands already decoded from frames; one command at a time
// Notes:   read data streams after an OK status; update bytes are pulled
`timescale 1ns/1ps
`default_nettype none
`include "ndefac_defines.svh"
module ndefac_file_access_control #(
  parameter int           MEM_BYTES    = 8192,
  parameter logic [127:0] READ_SECRET  = 128'h0,
  parameter logic [127:0] WRITE_SECRET = 128'h0,
  parameter logic [7:0]   MAP_VERSION  = 8'h20,
  // Arbitrary serial and product code, not a real assignment
  parameter logic [55:0]  SERIAL       = 56'h0A5A112233_4455,
  parameter logic [7:0]   PRODUCT      = 8'h5A,
  parameter logic [7:0]   SYS_B6       = 8'h00
) (
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  // Session
  input  wire logic                sessionEnd,
  // Command and response
  input  wire logic                cmdValid,
  input  wire ndefac_pkg::ndefac_cmd_t cmd,
  output logic                     cmdReady,
  output ndefac_pkg::ndefac_rsp_t  rsp,
  // Read data stream
  output logic                     rdValid,
  output logic [7:0]               rdData,
  // Update data stream
  input  wire logic                wrValid,
  input  wire logic [7:0]          wrData,
  output logic                     wrReady
);
  import ndefac_pkg::*;
  localparam int AW = $clog2(MEM_BYTES);
  localparam logic [16:0] MEM_LIMIT = 17'(MEM_BYTES);

  // ==========================================================
  // State
  ndefac_state_t state;
  ndefac_file_t  fileSel;
  logic [7:0]    readRight;
  logic [7:0]    writeRight;
  logic          readGranted;
  logic          writeGranted;
  logic [15:0]   addr;
  logic [7:0]    remain;
  logic [15:0]   msgLen;
  logic [7:0]    mem [MEM_BYTES];
  logic          accept;
  logic          wrTake;
  logic          wrLast;

  // ==========================================================
  // Decision
  ndefac_file_t  next_fileSel;
  logic [7:0]    next_readRight;
  logic [7:0]    next_writeRight;
  logic [15:0]   decStatus;
  logic          goRead;
  logic          goWrite;
  logic          clrGrants;
  logic          setRdGrant;
  logic          setWrGrant;
  logic [16:0]   spanEnd;
  logic [16:0]   limit;
  logic          readOk;
  logic          writeOk;
  logic [7:0]    byteOut;

  assign cmdReady = (state == ST_IDLE);
  assign accept   = cmdValid && cmdReady;
  assign wrReady  = (state == ST_WRITE);
  assign wrTake   = wrValid && wrReady;
  assign wrLast   = wrTake && (remain == 8'h01);
  assign spanEnd  = {1'b0, cmd.offset} + {9'h000, cmd.length};

  always_comb begin
    case (fileSel)
      FS_CC:   limit = {1'b0, `CC_LEN};
      FS_SYS:  limit = {1'b0, `SYS_LEN};
      default: limit = {1'b0, msgLen} + 17'h00002;
    endcase
  end

  // Right byte decode
  assign readOk  = (readRight == `RIGHT_FREE) ||
                   ((readRight == `RIGHT_LOCKED) && readGranted);
  assign writeOk = (writeRight == `RIGHT_FREE) ||
                   ((writeRight == `RIGHT_LOCKED) && writeGranted);

  always_comb begin
    next_fileSel    = fileSel;
    next_readRight  = readRight;
    next_writeRight = writeRight;
    decStatus       = `SW_OK;
    goRead          = 1'b0;
    goWrite         = 1'b0;
    clrGrants       = 1'b0;
    setRdGrant      = 1'b0;
    setWrGrant      = 1'b0;
    case (cmd.op)
      OP_SELECT: begin
        case (cmd.user_file_identifier)
          `FID_SYS:  next_fileSel = FS_SYS;
          `FID_CC:   next_fileSel = FS_CC;
          `FID_NDEF: next_fileSel = FS_NDEF;
          default:   decStatus = `SW_NOT_FOUND;
        endcase
        clrGrants = (next_fileSel != fileSel);
      end
      OP_READ: begin
        if (fileSel == FS_NONE) begin
          decStatus = `SW_NO_SELECT;
        end else if (fileSel == FS_NDEF && !readOk) begin
          decStatus = `SW_SECURITY;
        end else if (spanEnd > limit) begin
          decStatus = `SW_WRONG_PARAM;
        end else begin
          goRead = (cmd.length != 8'h00);
        end
      end
      OP_UPDATE: begin
        if (fileSel == FS_NONE) begin
          decStatus = `SW_NO_SELECT;
        end else if (fileSel != FS_NDEF) begin
          decStatus = `SW_READ_ONLY;
        end else if (!writeOk) begin
          decStatus = `SW_SECURITY;
        end else if (spanEnd > MEM_LIMIT) begin
          decStatus = `SW_WRONG_PARAM;
        end else begin
          goWrite = (cmd.length != 8'h00);
        end
      end
      OP_VFY_RD, OP_VFY_WR: begin
        if (fileSel != FS_NDEF) begin
          decStatus = `SW_NO_SELECT;
        end else if (cmd.op == OP_VFY_RD) begin
          if (cmd.secret != READ_SECRET) begin
            decStatus = `SW_WRONG_PW;
          end else begin
            setRdGrant = 1'b1;
          end
        end else if (cmd.secret != WRITE_SECRET) begin
          decStatus = `SW_WRONG_PW;
        end else begin
          setWrGrant = 1'b1;
        end
      end
      OP_SET_RD: begin
        if (fileSel != FS_NDEF) begin
          decStatus = `SW_NO_SELECT;
        end else if (!writeGranted) begin
          decStatus = `SW_SECURITY;
        end else if (readRight == `RIGHT_NO_READ) begin
          decStatus = `SW_SECURITY;
        end else if (cmd.newRight == `RIGHT_FREE ||
                     cmd.newRight == `RIGHT_LOCKED ||
                     cmd.newRight == `RIGHT_NO_READ) begin
          next_readRight = cmd.newRight;
        end else begin
          decStatus = `SW_WRONG_DATA;
        end
      end
      OP_SET_WR: begin
        if (fileSel != FS_NDEF) begin
          decStatus = `SW_NO_SELECT;
        end else if (!writeGranted) begin
          decStatus = `SW_SECURITY;
        end else if (writeRight == `RIGHT_NO_WRITE) begin
          decStatus = `SW_SECURITY;
        end else if (cmd.newRight == `RIGHT_FREE ||
                     cmd.newRight == `RIGHT_LOCKED ||
                     cmd.newRight == `RIGHT_NO_WRITE) begin
          next_writeRight = cmd.newRight;
        end else begin
          decStatus = `SW_WRONG_DATA;
        end
      end
      default: decStatus = `SW_BAD_INS;
    endcase
  end

  // ==========================================================
  // File contents
  function automatic logic [7:0] ccByte(input logic [3:0] off);
    case (off)
      `CC_OFF_LEN:         ccByte = 8'(`CC_LEN >> 8);
      `CC_OFF_LEN + 4'h1:  ccByte = 8'(`CC_LEN);
      `CC_OFF_MAP:         ccByte = MAP_VERSION;
      `CC_OFF_MAXRD:       ccByte = 8'(`CC_MAX_XFER >> 8);
      `CC_OFF_MAXRD + 4'h1: ccByte = 8'(`CC_MAX_XFER);
      `CC_OFF_MAXWR:       ccByte = 8'(`CC_MAX_XFER >> 8);
      `CC_OFF_MAXWR + 4'h1: ccByte = 8'(`CC_MAX_XFER);
      `CC_OFF_T:           ccByte = `CC_TLV_T;
      `CC_OFF_L:           ccByte = `CC_TLV_L;
      `CC_OFF_FID:         ccByte = 8'(`FID_NDEF >> 8);
      `CC_OFF_FID + 4'h1:  ccByte = 8'(`FID_NDEF);
      `CC_OFF_MAXSZ:       ccByte = 8'(`NDEF_MAX_SIZE >> 8);
      `CC_OFF_MAXSZ + 4'h1: ccByte = 8'(`NDEF_MAX_SIZE);
      `CC_OFF_RDR:         ccByte = readRight;
      `CC_OFF_WRR:         ccByte = writeRight;
      default:             ccByte = 8'h00;
    endcase
  endfunction : ccByte

  function automatic logic [7:0] sysByte(input logic [4:0] off);
    logic [4:0] u;
    u = off - `SYS_OFF_UID;
    if (off >= `SYS_OFF_UID && off < `SYS_OFF_MSZ) begin
      sysByte = SERIAL[8'(6 - u) * 8 +: 8];
    end else begin
      case (off)
        5'h00:              sysByte = 8'(`SYS_LEN >> 8);
        5'h01:              sysByte = 8'(`SYS_LEN);
        5'h02:              sysByte = `SYS_B2;
        5'h03:              sysByte = `SYS_B3;
        5'h04:              sysByte = `SYS_B4;
        5'h05:              sysByte = `SYS_B5;
        5'h06:              sysByte = SYS_B6;
        5'h07:              sysByte = `SYS_B7;
        `SYS_OFF_MSZ:       sysByte = 8'(`SYS_MEM_SIZE >> 8);
        `SYS_OFF_MSZ + 5'h1: sysByte = 8'(`SYS_MEM_SIZE);
        `SYS_OFF_PC:        sysByte = PRODUCT;
        default:            sysByte = 8'h00;
      endcase
    end
  endfunction : sysByte

  always_comb begin
    case (fileSel)
      FS_CC:   byteOut = ccByte(addr[3:0]);
      FS_SYS:  byteOut = sysByte(addr[4:0]);
      default: byteOut = mem[addr[AW-1:0]];
    endcase
  end

  // ==========================================================
  // Sequencer
  always_ff @(posedge clk_sys) begin
    if (!rst_n || sessionEnd) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (accept && goRead) begin
            state <= ST_READ;
          end else if (accept && goWrite) begin
            state <= ST_WRITE;
          end
        end
        ST_READ:  if (remain == 8'h01) state <= ST_IDLE;
        ST_WRITE: if (wrLast) state <= ST_IDLE;
        default:  state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      addr   <= 16'h0000;
      remain <= 8'h00;
    end else if (accept) begin
      addr   <= cmd.offset;
      remain <= cmd.length;
    end else if (state == ST_READ || wrTake) begin
      addr   <= addr + 16'h0001;
      remain <= remain - 8'h01;
    end
  end

  // Response only follows a command or the last update byte
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rsp <= '0;
    end else begin
      rsp.valid <= (accept && !goWrite) || wrLast;
      if (accept) begin
        rsp.status <= decStatus;
      end else if (wrLast) begin
        rsp.status <= `SW_OK;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rdValid <= 1'b0;
      rdData  <= 8'h00;
    end else begin
      rdValid <= (state == ST_READ) && !sessionEnd;
      if (state == ST_READ) begin
        rdData <= byteOut;
      end
    end
  end

  // Message length is host data; shadowed for the read bound only
  always_ff @(posedge clk_sys) begin
    if (wrTake) begin
      mem[addr[AW-1:0]] <= wrData;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      msgLen <= 16'h0000;
    end else if (wrTake && addr == 16'h0000) begin
      msgLen[15:8] <= wrData;
    end else if (wrTake && addr == 16'h0001) begin
      msgLen[7:0] <= wrData;
    end
  end

  // ==========================================================
  // Selection, rights and grants
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      fileSel <= FS_NONE;
    end else if (accept) begin
      fileSel <= next_fileSel;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      readRight  <= `RIGHT_FREE;
      writeRight <= `RIGHT_FREE;
    end else if (accept) begin
      readRight  <= next_readRight;
      writeRight <= next_writeRight;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n || sessionEnd) begin
      readGranted  <= 1'b0;
      writeGranted <= 1'b0;
    end else if (accept && clrGrants) begin
      readGranted  <= 1'b0;
      writeGranted <= 1'b0;
    end else if (accept) begin
      readGranted  <= readGranted || setRdGrant;
      writeGranted <= writeGranted || setWrGrant;
    end
  end

  // ==========================================================
  // Checks
  property p_selUnknown;
    @(posedge clk_sys) disable iff (!rst_n)
    accept && cmd.op == OP_SELECT && cmd.user_file_identifier != `FID_SYS &&
    cmd.user_file_identifier != `FID_CC && cmd.user_file_identifier != `FID_NDEF
    |=> rsp.valid && rsp.status == `SW_NOT_FOUND && $stable(fileSel);
  endproperty
  a_selUnknown: assert property (p_selUnknown)
    else $error("unknown select changed selection");

  property p_ccReadOnly;
    @(posedge clk_sys) disable iff (!rst_n)
    accept && cmd.op == OP_UPDATE && fileSel == FS_CC
    |=> rsp.status == `SW_READ_ONLY && state == ST_IDLE;
  endproperty
  a_ccReadOnly: assert property (p_ccReadOnly)
    else $error("container update not refused");

  property p_permRead;
    @(posedge clk_sys) disable iff (!rst_n)
    readRight == `RIGHT_NO_READ |=> readRight == `RIGHT_NO_READ;
  endproperty
  a_permRead: assert property (p_permRead)
    else $error("read denial state left");

  property p_permWrite;
    @(posedge clk_sys) disable iff (!rst_n)
    writeRight == `RIGHT_NO_WRITE |=> writeRight == `RIGHT_NO_WRITE;
  endproperty
  a_permWrite: assert property (p_permWrite)
    else $error("write denial state left");

  property p_lockedRead;
    @(posedge clk_sys) disable iff (!rst_n)
    accept && cmd.op == OP_READ && fileSel == FS_NDEF &&
    readRight == `RIGHT_LOCKED && !readGranted
    |=> rsp.status == `SW_SECURITY ##1 !rdValid;
  endproperty
  a_lockedRead: assert property (p_lockedRead)
    else $error("locked read served");

  property p_lockedWrite;
    @(posedge clk_sys) disable iff (!rst_n)
    accept && cmd.op == OP_UPDATE && fileSel == FS_NDEF &&
    writeRight != `RIGHT_FREE && !(writeRight == `RIGHT_LOCKED && writeGranted)
    |=> rsp.status == `SW_SECURITY && !wrReady;
  endproperty
  a_lockedWrite: assert property (p_lockedWrite)
    else $error("locked update accepted");

  property p_setNeedsSecret;
    @(posedge clk_sys) disable iff (!rst_n)
    accept && !writeGranted |=> $stable(readRight) && $stable(writeRight);
  endproperty
  a_setNeedsSecret: assert property (p_setNeedsSecret)
    else $error("right changed without write secret");

  property p_grantClear;
    @(posedge clk_sys) disable iff (!rst_n)
    sessionEnd |=> !readGranted && !writeGranted && state == ST_IDLE;
  endproperty
  a_grantClear: assert property (p_grantClear)
    else $error("grants kept after session end");

  property p_readBound;
    @(posedge clk_sys) disable iff (!rst_n)
    accept && cmd.op == OP_READ && fileSel == FS_NDEF && readOk &&
    spanEnd > ({1'b0, msgLen} + 17'h00002)
    |=> rsp.status == `SW_WRONG_PARAM;
  endproperty
  a_readBound: assert property (p_readBound)
    else $error("read beyond message served");

  property p_silent;
    @(posedge clk_sys) disable iff (!rst_n)
    rsp.valid |-> $past(accept) || $past(wrLast);
  endproperty
  a_silent: assert property (p_silent)
    else $error("response without command");

endmodule : ndefac_file_access_control
`default_nettype wire

// file: verif/ndefac_host_model.sv
// Purpose: reader side model issuing commands and update bytes
// Assumes: tasks are entered one step after a rising clock edge
// Notes:   idle lines show changing values, never a stale byte
`timescale 1ns/1ps
`default_nettype none
module ndefac_host_model (
  // Clock
  input  wire logic                    clk_sys,
  // Handshakes from the tag
  input  wire logic                    cmdReady,
  input  wire logic                    wrReady,
  // Command and update data
  output logic                         cmdValid,
  output ndefac_pkg::ndefac_cmd_t      cmd,
  output logic                         wrValid,
  output logic [7:0]                   wrData
);
  import ndefac_pkg::*;
  initial begin
    cmdValid = 1'b0;
    cmd      = '0;
    wrValid  = 1'b0;
    wrData   = 8'h00;
  end
  // ==========================================================
  // Command, held until taken
  task automatic send(input ndefac_op_t o, input logic [15:0] f, off,
                      input logic [7:0] len, input logic [127:0] s,
                      input logic [7:0] nr);
    cmdValid = 1'b1;
    cmd      = '{o, f, off, len, s, nr};
    do @(posedge clk_sys); while (cmdReady !== 1'b1);
    #1;
    cmdValid = 1'b0;
    cmd      = ndefac_cmd_t'(~cmd);
    // Idle cycle so the next call never re-raises valid in this step
    @(posedge clk_sys);
    #1;
  endtask : send
  // ==========================================================
  // Update bytes, optionally stalled
  task automatic put(input logic [7:0] b[$], input int stall);
    foreach (b[i]) begin
      if (stall > 0) begin
        wrValid = 1'b0;
        repeat (stall) begin
          wrData = ~wrData;
          @(posedge clk_sys);
          #1;
        end
      end
      wrValid = 1'b1;
      wrData  = b[i];
      do @(posedge clk_sys); while (wrReady !== 1'b1);
      #1;
    end
    wrValid = 1'b0;
    wrData  = ~wrData;
  endtask : put
endmodule : ndefac_host_model
`default_nettype wire

// file: verif/ndefac_file_access_control_tb.sv
// Purpose: self-checking bench of the tag file access control
// Assumes: host model issues one command at a time
// Notes:   driver queues expectations, a monitor pops and compares
`timescale 1ns/1ps
`default_nettype none
`include "ndefac_defines.svh"
module ndefac_file_access_control_tb;
  import ndefac_pkg::*;
  localparam logic [127:0] RSEC = 128'h0F1E2D3C4B5A69788796A5B4C3D2E1F0;
  localparam logic [127:0] WSEC = 128'h13579BDF02468ACE13579BDF02468ACE;
  // Arbitrary serial, not a real assignment
  localparam logic [55:0]  SER  = 56'h0A1B2C3D4E5F60;
  localparam logic [7:0]   CCI [15] = '{8'h00, 8'h0F, 8'h20, 8'h00,
    8'hF6, 8'h00, 8'hF6, 8'h04, 8'h06, 8'h00, 8'h01, 8'h20, 8'h00,
    8'h00, 8'h00};
  logic        clk_sys    = 1'b0;
  logic        rst_n      = 1'b0;
  logic        sessionEnd = 1'b0;
  logic        cmdValid, cmdReady, rdValid, wrValid, wrReady;
  logic [7:0]  rdData, wrData;
  ndefac_cmd_t cmd;
  ndefac_rsp_t rsp;
  logic [15:0] stQ[$];
  logic [7:0]  rdQ[$];
  logic [7:0]  wb[$];
  int          errors      = 0;
  int          totalChecks = 0;
  int          seed        = 32'h06c3;
  always #20 clk_sys = ~clk_sys;
  ndefac_file_access_control #(.READ_SECRET(RSEC), .WRITE_SECRET(WSEC),
    .SERIAL(SER)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .sessionEnd(sessionEnd), .cmdValid(cmdValid), .cmd(cmd),
    .cmdReady(cmdReady), .rsp(rsp), .rdValid(rdValid), .rdData(rdData),
    .wrValid(wrValid), .wrData(wrData), .wrReady(wrReady));
  ndefac_host_model host (.clk_sys(clk_sys), .cmdReady(cmdReady),
    .wrReady(wrReady), .cmdValid(cmdValid), .cmd(cmd),
    .wrValid(wrValid), .wrData(wrData));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", totalChecks, errors);
    if (errors == 0 && totalChecks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [15:0] e, input logic [15:0] g);
    totalChecks++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  // ==========================================================
  // Monitor, missing expectation compares against unknown
  always @(posedge clk_sys) begin
    if (rsp.valid === 1'b1) begin
      chk(stQ.size() ? stQ.pop_front() : 16'hXXXX, rsp.status);
    end
    if (rdValid === 1'b1) begin
      chk(rdQ.size() ? {8'h00, rdQ.pop_front()} : 16'hXXXX, {8'h00, rdData});
    end
  end
  task automatic go(input ndefac_op_t o, input logic [15:0] st,
                    input logic [15:0] f = 16'h0000,
                    input logic [15:0] off = 16'h0000,
                    input logic [7:0] len = 8'h00,
                    input logic [127:0] sec = '0,
                    input logic [7:0] nr = 8'h00);
    stQ.push_back(st);
    host.send(o, f, off, len, sec, nr);
  endtask : go
  task automatic upd(input int stall, input logic [15:0] st);
    stQ.push_back(st);
    host.send(OP_UPDATE, 16'h0000, 16'h0000, 8'(wb.size()), '0, 8'h00);
    if (st == `SW_OK) host.put(wb, stall);
  endtask : upd
  task automatic done(input string n);
    $display("test %s finished", n);
  endtask : done
  initial begin
    #(40 * 5000);
    errors++;
    $display("watchdog expired");
    stop_test();
  end
  // ==========================================================
  // Main sequence
  initial begin
    repeat (8) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    go(OP_READ, `SW_NO_SELECT, .len(8'h01));
    go(OP_SELECT, `SW_NOT_FOUND, .f({4'h1, 12'($random(seed))}));
    go(OP_UPDATE, `SW_NO_SELECT, .len(8'h01));
    go(ndefac_op_t'(3'b111), `SW_BAD_INS);
    done("selection");
    go(OP_SELECT, `SW_OK, .f(`FID_CC));
    foreach (CCI[i]) rdQ.push_back(CCI[i]);
    go(OP_READ, `SW_OK, .len(8'h0F));
    go(OP_READ, `SW_WRONG_PARAM, .off(16'h0001), .len(8'h0F));
    go(OP_UPDATE, `SW_READ_ONLY, .len(8'h01));
    go(OP_SELECT, `SW_OK, .f(`FID_SYS));
    rdQ.push_back(8'h00);
    rdQ.push_back(8'h12);
    go(OP_READ, `SW_OK, .len(8'h02));
    go(OP_READ, `SW_WRONG_PARAM, .len(8'h13));
    for (int i = 6; i >= 0; i--) rdQ.push_back(SER[i*8 +: 8]);
    go(OP_READ, `SW_OK, .off(16'h0008), .len(8'h07));
    go(OP_UPDATE, `SW_READ_ONLY, .off(16'h0008), .len(8'h01));
    done("files");
    go(OP_SELECT, `SW_OK, .f(`FID_NDEF));
    // Length says one byte of message, four written: never cross-checked
    wb = '{8'h00, 8'h01, 8'($random(seed)), 8'($random(seed))};
    upd(0, `SW_OK);
    for (int i = 0; i < 3; i++) rdQ.push_back(wb[i]);
    go(OP_READ, `SW_OK, .len(8'h03));
    go(OP_READ, `SW_WRONG_PARAM, .len(8'h04));
    done("message");
    go(OP_VFY_WR, `SW_WRONG_PW, .sec({RSEC[127:32], 32'($random(seed))}));
    go(OP_SET_RD, `SW_SECURITY, .nr(8'h80));
    go(OP_VFY_WR, `SW_OK, .sec(WSEC));
    go(OP_SET_RD, `SW_WRONG_DATA, .nr(8'h55));
    go(OP_SET_RD, `SW_OK, .nr(8'h80));
    go(OP_SET_WR, `SW_OK, .nr(8'h80));
    go(OP_SELECT, `SW_OK, .f(`FID_CC));
    rdQ.push_back(8'h80);
    rdQ.push_back(8'h80);
    go(OP_READ, `SW_OK, .off(16'h000D), .len(8'h02));
    go(OP_SELECT, `SW_OK, .f(`FID_NDEF));
    go(OP_READ, `SW_SECURITY, .len(8'h01));
    upd(0, `SW_SECURITY);
    go(OP_VFY_RD, `SW_OK, .sec(RSEC));
    rdQ.push_back(8'h00);
    go(OP_READ, `SW_OK, .len(8'h01));
    go(OP_VFY_WR, `SW_OK, .sec(WSEC));
    sessionEnd = 1'b1;
    @(posedge clk_sys);
    #1 sessionEnd = 1'b0;
    upd(0, `SW_SECURITY);
    go(OP_VFY_WR, `SW_OK, .sec(WSEC));
    upd(2, `SW_OK);
    done("locks");
    go(OP_SET_RD, `SW_OK, .nr(8'hFE));
    go(OP_VFY_RD, `SW_OK, .sec(RSEC));
    go(OP_READ, `SW_SECURITY, .len(8'h01));
    go(OP_SET_RD, `SW_SECURITY, .nr(8'h00));
    go(OP_SET_WR, `SW_OK, .nr(8'hFF));
    upd(0, `SW_SECURITY);
    go(OP_SET_WR, `SW_SECURITY, .nr(8'h80));
    repeat (10) @(posedge clk_sys);
    if (stQ.size() != 0 || rdQ.size() != 0) begin
      errors++;
      $display("unexpected at %0t: left %h want %h", $time,
               stQ.size() + rdQ.size(), 0);
    end
    done("permanent");
    stop_test();
  end
endmodule : ndefac_file_access_control_tb
`default_nettype wire
